/* verilog/uart_imc_regs.svh */
`ifndef UART_IMC_REGS_SVH
`define UART_IMC_REGS_SVH

// word-aligned byte offsets on the register bus
`define OFS_IRQ_EN     5'h04
`define OFS_IRQ_ID     5'h08
`define OFS_MDM_CTL    5'h10
`define OFS_MDM_STAT   5'h18
`define OFS_SCR        5'h1c

`define IRQ_EN_RST     4'h0
`define MDM_CTL_RST    5'h00
`define SCR_RST        8'h00
`define TRIG_RST       2'h0

// enable register fields
`define EN_RX          0
`define EN_TXE         1
`define EN_LS          2
`define EN_MS          3
// modem control fields
`define CTL_DTR        0
`define CTL_RTS        1
`define CTL_AUX1       2
`define CTL_AUX2       3
`define CTL_LOOP       4
// fifo control fields
`define FCR_EN         0
`define FCR_RXCLR      1
`define FCR_TXCLR      2
`define FCR_TRIG_LO    6
`define FCR_TRIG_HI    7

// receive trigger levels in bytes
`define TRIG_LVL0      5'd1
`define TRIG_LVL1      5'd4
`define TRIG_LVL2      5'd8
`define TRIG_LVL3      5'd14

// receive timeout: character times, baud ticks per bit
`define TO_CHAR_TIMES  4
`define BAUD_OVERSAMPLE 16

`endif

/* verilog/uart_imc_pkg.sv */
`default_nettype none
package uart_imc_pkg;
	// identity code, bits 3:1 of the identity register
	typedef enum logic [2:0] {
		ID_MS   = 3'b000,
		ID_TXE  = 3'b001,
		ID_RX   = 3'b010,
		ID_LS   = 3'b011,
		ID_TO   = 3'b110
	} irq_id_t;
	typedef logic [1:0] trig_sel_t;
endpackage
`default_nettype wire

/* verilog/uart_irq_modem_ctrl.sv */
// How it works
// - priority: line status, received data, holding empty, modem status
// - identity read freezes the interrupt output; new events still record
// - identity bit 0 reads 0 when an enabled interrupt pends, else 1
// - identity bit 3 flags character timeout, only in fifo mode
// - identity bits 5:4 read 0; bits 7:6 read 1 when fifos enabled
// - disabled sources neither show in identity nor raise the output
// - enable bit 0 gates received data and, in fifo mode, timeout
// - enable bit 2 line status, bit 3 modem status; bits 7:4 read 0
// - control bits 3:0 drive the four modem output pins inverted
// - loopback holds serial out at mark and routes transmit into receive
// - loopback detaches modem inputs, feeds control bits, pins go high
// - in loopback interrupts still work; modem sources are control bits
// - change flags on cts, dsr, dcd edges; ring flag on trailing edge
// - reading modem status clears change flags; any flag raises interrupt
// - status bits 7:4 show active modem inputs, or control bits in loopback
// - eight-bit scratch register with no side effect
// - fifo mode receive interrupt follows the trigger level both ways
// - line status outranks received data, and received data outranks timeout
// - timeout after four idle character times with data in the fifo
// - a fifo read or a new character restarts the timeout timer
// - holding empty sets when fifo empties; cleared by write or by an identity read that reports it
// - with receive interrupts off, neither trigger nor timeout is reported
// - fifo enable bit activates both fifos; toggling it empties them
// - fifo control bits 7:6 choose the receive trigger level
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`include "uart_imc_regs.svh"
`default_nettype none
module uart_irq_modem_ctrl #(
	parameter int CHAR_BITS = 10,
	parameter int CNT_W     = 5
) (
	input  wire logic        CLK_SYS,        // system clock, 200 MHz
	input  wire logic        SYS_RST,        // async reset, active high
	input  wire logic        CYC_I,          // wishbone cycle
	input  wire logic        STB_I,          // wishbone strobe
	input  wire logic        WE_I,           // wishbone write
	input  wire logic [4:0]  ADR_I,          // byte address
	input  wire logic [31:0] DAT_I,          // write data
	input  wire logic [3:0]  SEL_I,          // byte lanes
	output logic      [31:0] DAT_O,          // read data
	output logic             ACK_O,          // wishbone acknowledge
	output logic             IRQ_OUT,        // interrupt, active high
	input  wire logic        CTS_N,          // clear to send pin
	input  wire logic        DSR_N,          // data set ready pin
	input  wire logic        RI_N,           // ring indicator pin
	input  wire logic        DCD_N,          // carrier detect pin
	output logic             DTR_N,          // data terminal ready pin
	output logic             RTS_N,          // request to send pin
	output logic             AUX_OUTPUT_ONE_N, // auxiliary output one
	output logic             AUX_OUTPUT_TWO_N, // auxiliary output two
	input  wire logic        SERIAL_RX_PIN,  // serial input pin
	output logic             SERIAL_TX_PIN,  // serial output pin
	input  wire logic        TX_SHIFT_OUT,   // transmit shifter output
	output logic             RX_SHIFT_IN,    // receive shifter input
	input  wire logic [CNT_W-1:0] RX_FIFO_COUNT, // characters held
	input  wire logic        RX_CHAR_STORED, // pulse: character stored
	input  wire logic        RX_FIFO_READ,   // pulse: host read a char
	input  wire logic        LINE_ERROR,     // any line error flag set
	input  wire logic        TX_FIFO_EMPTY,  // transmit holding empty
	input  wire logic        THR_WRITE,      // pulse: holding reg write
	input  wire logic        RX_BAUD_TICK,   // one per 16x receive tick
	output logic             FIFO_ENABLE,    // fifo mode active
	output logic             RX_FIFO_CLEAR,  // pulse: empty rx fifo
	output logic             TX_FIFO_CLEAR   // pulse: empty tx fifo
);
	import uart_imc_pkg::*;

	localparam int TO_TICKS_I = `TO_CHAR_TIMES * `BAUD_OVERSAMPLE * CHAR_BITS;
	localparam logic [15:0] TO_TICKS = 16'(TO_TICKS_I);

	initial begin
		if (CHAR_BITS < 7 || CHAR_BITS > 12)
			$error("CHAR_BITS out of range");
		if (CNT_W < 5)
			$error("CNT_W too narrow for trigger 14");
	end

	logic        ack_reg;
	logic [7:0]  rd_reg;
	logic [3:0]  irq_en_reg;
	logic [4:0]  mdm_ctl_reg;
	logic [7:0]  scr_reg;
	logic        fifo_en_reg;
	trig_sel_t   trig_reg;
	logic        rxclr_reg;
	logic        txclr_reg;
	logic        irq_reg;
	logic        txe_reg;
	logic        tx_empty_prev_reg;
	logic [3:0]  pin_s1_reg;
	logic [3:0]  pin_s2_reg;
	logic [3:0]  act_prev_reg;
	logic [3:0]  delta_reg;
	logic        rx_s1_reg;
	logic        rx_s2_reg;
	logic        rx_in_reg;
	logic        tx_pin_reg;
	logic [3:0]  modem_pin_reg;
	logic [15:0] to_cnt_reg;

	logic        req;
	logic        wr;
	logic        rd;
	logic        id_access;
	logic        loop;
	logic [3:0]  act;
	logic [3:0]  delta_set;
	logic [CNT_W-1:0] trig_lvl;
	logic        rx_pend;
	logic        to_pend;
	logic        ls_e;
	logic        rx_e;
	logic        to_e;
	logic        th_e;
	logic        ms_e;
	logic        any_pend;
	irq_id_t     id_code;
	logic [7:0]  id_val;
	logic [7:0]  rd_mux;

	// one wait state: ack follows the request edge, then drops
	assign req  = CYC_I & STB_I & ~ack_reg;
	assign wr   = req & WE_I & SEL_I[0];
	assign rd   = req & ~WE_I;
	assign loop = mdm_ctl_reg[`CTL_LOOP];
	assign id_access = CYC_I & STB_I & ~WE_I & (ADR_I == `OFS_IRQ_ID);

	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
			ack_reg <= 1'b0;
		else
			ack_reg <= req;
	end

	// the identity value is captured once, so the read is atomic
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
			rd_reg <= 8'h00;
		else if (rd)
			rd_reg <= rd_mux;
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			irq_en_reg  <= `IRQ_EN_RST;
			mdm_ctl_reg <= `MDM_CTL_RST;
			scr_reg <= `SCR_RST;
		end
		else if (wr)
		begin
			if (ADR_I == `OFS_IRQ_EN)
				irq_en_reg <= DAT_I[3:0];
			if (ADR_I == `OFS_MDM_CTL)
				mdm_ctl_reg <= DAT_I[4:0];
			if (ADR_I == `OFS_SCR)
				scr_reg <= DAT_I[7:0];
		end
	end

	// fifo control shares the identity offset on writes
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			fifo_en_reg <= 1'b0;
			trig_reg    <= `TRIG_RST;
			rxclr_reg   <= 1'b0;
			txclr_reg   <= 1'b0;
		end
		else if (wr && ADR_I == `OFS_IRQ_ID)
		begin
			fifo_en_reg <= DAT_I[`FCR_EN];
			if (DAT_I[`FCR_EN])
				trig_reg <= DAT_I[`FCR_TRIG_HI:`FCR_TRIG_LO];
			rxclr_reg <= (DAT_I[`FCR_EN] != fifo_en_reg) |
				(DAT_I[`FCR_EN] & DAT_I[`FCR_RXCLR]);
			txclr_reg <= (DAT_I[`FCR_EN] != fifo_en_reg) |
				(DAT_I[`FCR_EN] & DAT_I[`FCR_TXCLR]);
		end
		else
		begin
			rxclr_reg <= 1'b0;
			txclr_reg <= 1'b0;
		end
	end

	always_comb
	begin
		case (trig_reg)
			2'h0:    trig_lvl = CNT_W'(`TRIG_LVL0);
			2'h1:    trig_lvl = CNT_W'(`TRIG_LVL1);
			2'h2:    trig_lvl = CNT_W'(`TRIG_LVL2);
			2'h3:    trig_lvl = CNT_W'(`TRIG_LVL3);
			default: trig_lvl = CNT_W'(`TRIG_LVL0);
		endcase
	end

	// timer runs on receive ticks, so the delay scales with the baud rate
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
			to_cnt_reg <= 16'h0000;
		else if (!fifo_en_reg || RX_CHAR_STORED || RX_FIFO_READ ||
			RX_FIFO_COUNT == '0)
			to_cnt_reg <= 16'h0000;
		else if (RX_BAUD_TICK && to_cnt_reg != TO_TICKS)
			to_cnt_reg <= to_cnt_reg + 16'h0001;
	end

	assign rx_pend = fifo_en_reg ? (RX_FIFO_COUNT >= trig_lvl)
		: (RX_FIFO_COUNT != '0);
	assign to_pend = fifo_en_reg & (RX_FIFO_COUNT != '0) &
		(to_cnt_reg == TO_TICKS);

	// set wins over the clear so an empty edge is never lost
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			txe_reg           <= 1'b0;
			tx_empty_prev_reg <= 1'b0;
		end
		else
		begin
			tx_empty_prev_reg <= TX_FIFO_EMPTY;
			if ((TX_FIFO_EMPTY & ~tx_empty_prev_reg) |
				(wr & (ADR_I == `OFS_IRQ_EN) & DAT_I[`EN_TXE] &
				~irq_en_reg[`EN_TXE] & TX_FIFO_EMPTY))
				txe_reg <= 1'b1;
			else if (THR_WRITE | (rd & id_access & any_pend &
				(id_code == ID_TXE)))
				txe_reg <= 1'b0;
		end
	end

	assign ls_e = irq_en_reg[`EN_LS] & LINE_ERROR;
	assign rx_e = irq_en_reg[`EN_RX] & rx_pend;
	assign to_e = irq_en_reg[`EN_RX] & to_pend;
	assign th_e = irq_en_reg[`EN_TXE] & txe_reg;
	assign ms_e = irq_en_reg[`EN_MS] & (|delta_reg);
	assign any_pend = ls_e | rx_e | to_e | th_e | ms_e;

	always_comb
	begin
		if (ls_e)
			id_code = ID_LS;
		else if (rx_e)
			id_code = ID_RX;
		else if (to_e)
			id_code = ID_TO;
		else if (th_e)
			id_code = ID_TXE;
		else
			id_code = ID_MS;
	end

	assign id_val = {{2{fifo_en_reg}}, 2'b00, id_code, ~any_pend};

	always_comb
	begin
		case (ADR_I)
			`OFS_IRQ_EN:   rd_mux = {4'h0, irq_en_reg};
			`OFS_IRQ_ID:   rd_mux = id_val;
			`OFS_MDM_CTL:  rd_mux = {3'h0, mdm_ctl_reg};
			`OFS_MDM_STAT: rd_mux = {act, delta_reg};
			`OFS_SCR:      rd_mux = scr_reg;
			default:       rd_mux = 8'h00;
		endcase
	end

	// output holds still while software walks the identity register
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
			irq_reg <= 1'b0;
		else if (!id_access)
			irq_reg <= any_pend;
	end

	// modem inputs: {dcd, ri, dsr, cts}, pins active low
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			pin_s1_reg   <= 4'hf;
			pin_s2_reg   <= 4'hf;
			act_prev_reg <= 4'h0;
		end
		else
		begin
			pin_s1_reg   <= {DCD_N, RI_N, DSR_N, CTS_N};
			pin_s2_reg   <= pin_s1_reg;
			act_prev_reg <= act;
		end
	end

	// entering or leaving loopback can itself flag a change
	assign act = loop ? {mdm_ctl_reg[`CTL_AUX2], mdm_ctl_reg[`CTL_AUX1],
		mdm_ctl_reg[`CTL_DTR], mdm_ctl_reg[`CTL_RTS]}
		: ~pin_s2_reg;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_delta
			if (gi == 2)
				assign delta_set[gi] = act_prev_reg[gi] & ~act[gi];
			else
				assign delta_set[gi] = act_prev_reg[gi] ^ act[gi];
			always_ff @(posedge CLK_SYS or posedge SYS_RST)
			begin
				if (SYS_RST)
					delta_reg[gi] <= 1'b0;
				else if (delta_set[gi])
					delta_reg[gi] <= 1'b1;
				else if (rd && ADR_I == `OFS_MDM_STAT)
					delta_reg[gi] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			rx_s1_reg     <= 1'b1;
			rx_s2_reg     <= 1'b1;
			rx_in_reg     <= 1'b1;
			tx_pin_reg    <= 1'b1;
			modem_pin_reg <= 4'hf;
		end
		else
		begin
			rx_s1_reg  <= SERIAL_RX_PIN;
			rx_s2_reg  <= rx_s1_reg;
			rx_in_reg  <= loop ? TX_SHIFT_OUT : rx_s2_reg;
			tx_pin_reg <= loop | TX_SHIFT_OUT;
			modem_pin_reg <= loop ? 4'hf : ~mdm_ctl_reg[3:0];
		end
	end

	assign DAT_O         = {24'h000000, rd_reg};
	assign ACK_O         = ack_reg;
	assign IRQ_OUT       = irq_reg;
	assign DTR_N         = modem_pin_reg[`CTL_DTR];
	assign RTS_N         = modem_pin_reg[`CTL_RTS];
	assign AUX_OUTPUT_ONE_N = modem_pin_reg[`CTL_AUX1];
	assign AUX_OUTPUT_TWO_N = modem_pin_reg[`CTL_AUX2];
	assign SERIAL_TX_PIN = tx_pin_reg;
	assign RX_SHIFT_IN   = rx_in_reg;
	assign FIFO_ENABLE   = fifo_en_reg;
	assign RX_FIFO_CLEAR = rxclr_reg;
	assign TX_FIFO_CLEAR = txclr_reg;

	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);

	chk_ls_priority: assert property (ls_e |-> id_code == ID_LS)
		else $error("line status not top priority");
	chk_id_freeze: assert property (id_access && $past(id_access)
		|-> $stable(irq_reg))
		else $error("interrupt moved during identity read");
	chk_pend_bit: assert property (rd && id_access
		|=> DAT_O[0] == $past(!any_pend))
		else $error("pending bit wrong");
	chk_id_upper: assert property (rd && id_access
		|=> DAT_O[7:4] == {{2{fifo_en_reg}}, 2'b00})
		else $error("identity upper bits wrong");
	chk_all_disabled: assert property (irq_en_reg == 4'h0 |-> !any_pend)
		else $error("disabled source pending");
	chk_pin_invert: assert property (!loop ##1 !loop
		|-> DTR_N == !$past(mdm_ctl_reg[`CTL_DTR]))
		else $error("dtr pin not inverted");
	chk_loop_mark: assert property (loop |=> SERIAL_TX_PIN)
		else $error("serial out not at mark in loopback");
	chk_ring_edge: assert property (act_prev_reg[2] && !act[2]
		|=> delta_reg[2])
		else $error("ring trailing edge missed");
	chk_status_clear: assert property (rd && ADR_I == `OFS_MDM_STAT &&
		!(|delta_set) |=> delta_reg == 4'h0)
		else $error("change flags not cleared");
	chk_timeout_cond: assert property (to_e
		|-> fifo_en_reg && RX_FIFO_COUNT != '0)
		else $error("timeout without data");

	cov_ls_read: cover property (rd && id_access && ls_e);
	cov_loopback: cover property (loop && ms_e);
	cov_timeout: cover property (to_e ##1 RX_FIFO_READ);
	cov_tx_holding_empty_flag_clr: cover property (th_e ##1 THR_WRITE);
endmodule
`default_nettype wire

/* sim/modem_far_end.sv */
`default_nettype none
module modem_far_end (
	input  wire logic       clk,       // system clock
	input  wire logic [3:0] act,       // wanted active {dcd, ri, dsr, cts}
	input  wire logic       rx_line,   // serial level to send
	output logic            cts_n,     // clear to send, active low
	output logic            dsr_n,     // data set ready, active low
	output logic            ri_n,      // ring, active low
	output logic            dcd_n,     // carrier detect, active low
	output logic            serial_rx  // serial line into the device
);
	timeunit 1ns;
	timeprecision 1ps;

	// lines start inactive and idle at mark, as a silent modem would
	initial
	begin
		{dcd_n, ri_n, dsr_n, cts_n} = 4'hf;
		serial_rx = 1'b1;
	end

	// a modem line moves one edge after it is asked to
	always_ff @(posedge clk)
	begin
		{dcd_n, ri_n, dsr_n, cts_n} <= ~act;
		serial_rx <= rx_line;
	end
endmodule
`default_nettype wire

/* sim/testbench.sv */
`include "uart_imc_regs.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
	logic [4:0]  adr = 0, cnt = 0;
	logic [31:0] wdat = 0, rdat;
	logic [3:0]  sel = 0, act = 0;
	logic        txs = 1, rxp = 1, stored = 0, fread = 0, lerr = 0;
	logic        txe = 0, thw = 0, tick = 0;
	logic        ack, irq, dtr_n, rts_n, a1_n, a2_n, stx, rsi, fen;
	logic        cts_n, dsr_n, ri_n, dcd_n, srx, rclr, tclr;
	int          clr_cnt = 0;
	logic [7:0]  exp_q[$], msk_q[$], d;
	int          error_cnt = 0, tests_run = 0;
	int          lvl[4] = '{1, 4, 8, 14};

	always #2.5 clk = ~clk;

	modem_far_end far (.clk(clk), .act(act), .rx_line(rxp), .cts_n(cts_n),
		.dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n), .serial_rx(srx));

	uart_irq_modem_ctrl dut (.CLK_SYS(clk), .SYS_RST(rst), .CYC_I(cyc),
		.STB_I(stb), .WE_I(we), .ADR_I(adr), .DAT_I(wdat), .SEL_I(sel),
		.DAT_O(rdat), .ACK_O(ack), .IRQ_OUT(irq), .CTS_N(cts_n),
		.DSR_N(dsr_n), .RI_N(ri_n), .DCD_N(dcd_n), .DTR_N(dtr_n),
		.RTS_N(rts_n), .AUX_OUTPUT_ONE_N(a1_n), .AUX_OUTPUT_TWO_N(a2_n),
		.SERIAL_RX_PIN(srx), .SERIAL_TX_PIN(stx), .TX_SHIFT_OUT(txs),
		.RX_SHIFT_IN(rsi), .RX_FIFO_COUNT(cnt), .RX_CHAR_STORED(stored),
		.RX_FIFO_READ(fread), .LINE_ERROR(lerr), .TX_FIFO_EMPTY(txe),
		.THR_WRITE(thw), .RX_BAUD_TICK(tick), .FIFO_ENABLE(fen),
		.RX_FIFO_CLEAR(rclr), .TX_FIFO_CLEAR(tclr));

	// both clear pulses come together when fifo mode flips
	always @(posedge clk)
		if (rclr === 1'b1 && tclr === 1'b1)
			clr_cnt++;

	task automatic results();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// masked bits are ones the design may set either way
	task automatic cmp(input string n, input logic [7:0] e,
		input logic [7:0] g, input logic [7:0] m);
		tests_run++;
		if (((g ^ e) & m) !== 8'h00)
		begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic wb(input logic w, input logic [4:0] a,
		input logic [7:0] v, input logic [3:0] s);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= {24'h0, v};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			error_cnt++;
			results();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		wb(1'b1, a, v, 4'h1);
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] e,
		input logic [7:0] m = 8'hff);
		exp_q.push_back(e);
		msk_q.push_back(m);
		wb(1'b0, a, 8'h00, 4'hf);
	endtask

	always @(posedge clk)
		if (ack === 1'b1 && we === 1'b0)
			cmp("bus read", exp_q.pop_front(), rdat[7:0], msk_q.pop_front());

	initial
	begin
		void'($urandom(32'h3fad));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(`OFS_IRQ_EN, 8'h00);
		rd(`OFS_MDM_CTL, 8'h00);
		rd(`OFS_SCR, 8'h00);
		rd(`OFS_IRQ_ID, 8'h01);
		rd(5'h0c, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			d = 8'($urandom);
			wr(`OFS_SCR, d);
			rd(`OFS_SCR, d);
		end
		wb(1'b1, `OFS_SCR, ~d, 4'h0);
		rd(`OFS_SCR, d);
		wr(`OFS_IRQ_EN, 8'hff);
		rd(`OFS_IRQ_EN, 8'h0f);
		rd(`OFS_IRQ_ID, 8'h01);
		for (int m = 0; m < 16; m++)
		begin
			wr(`OFS_MDM_CTL, 8'(m));
			repeat (2) @(posedge clk);
			cmp("pins", {4'h0, ~4'(m)}, {4'h0, a2_n, a1_n, rts_n, dtr_n}, 8'hff);
		end
		// loopback with rts and aux two set; serial pin kept at mark
		wr(`OFS_MDM_CTL, 8'h1a);
		txs <= 1'b0;
		repeat (3) @(posedge clk);
		cmp("loop pins", 8'h1f, {3'h0, stx, a2_n, a1_n, rts_n, dtr_n}, 8'hff);
		cmp("loop rx", 8'h00, {7'h0, rsi}, 8'hff);
		txs <= 1'b1;
		rd(`OFS_MDM_STAT, 8'h90, 8'hf0);
		wr(`OFS_MDM_CTL, 8'h1b);
		repeat (4) @(posedge clk);
		rd(`OFS_IRQ_ID, 8'h00);
		rd(`OFS_MDM_STAT, 8'hb2);
		rd(`OFS_IRQ_ID, 8'h01);
		wr(`OFS_MDM_CTL, 8'h00);
		repeat (4) @(posedge clk);
		rd(`OFS_MDM_STAT, 8'h00, 8'hf0);
		rd(`OFS_MDM_STAT, 8'h00);
		// outside loopback the serial pins pass straight through
		rxp <= 1'b0;
		txs <= 1'b0;
		repeat (5) @(posedge clk);
		cmp("serial", 8'h00, {6'h0, stx, rsi}, 8'hff);
		rxp <= 1'b1;
		txs <= 1'b1;
		act <= 4'h1;
		repeat (8) @(posedge clk);
		cmp("irq", 8'h01, {7'h0, irq}, 8'hff);
		rd(`OFS_IRQ_ID, 8'h00);
		rd(`OFS_MDM_STAT, 8'h11);
		act <= 4'h5;
		repeat (8) @(posedge clk);
		rd(`OFS_MDM_STAT, 8'h50);
		act <= 4'h1;
		repeat (8) @(posedge clk);
		rd(`OFS_MDM_STAT, 8'h14);
		act <= 4'ha;
		repeat (8) @(posedge clk);
		rd(`OFS_MDM_STAT, 8'hab);
		act <= 4'h0;
		repeat (8) @(posedge clk);
		rd(`OFS_MDM_STAT, 8'h0a);
		cnt <= 5'd1;
		lerr <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`OFS_IRQ_ID, 8'h06);
		lerr <= 1'b0;
		repeat (3) @(posedge clk);
		rd(`OFS_IRQ_ID, 8'h04);
		wr(`OFS_IRQ_EN, 8'h0e);
		rd(`OFS_IRQ_ID, 8'h01);
		cmp("irq", 8'h00, {7'h0, irq}, 8'hff);
		cnt <= 5'd0;
		wr(`OFS_IRQ_EN, 8'h0f);
		for (int t = 0; t < 4; t++)
		begin
			wr(`OFS_IRQ_ID, {2'(t), 6'h01});
			cnt <= 5'(lvl[t] - 1);
			repeat (3) @(posedge clk);
			rd(`OFS_IRQ_ID, 8'hc1);
			cnt <= 5'(lvl[t]);
			repeat (3) @(posedge clk);
			rd(`OFS_IRQ_ID, 8'hc4);
		end
		cmp("fifo on", 8'h01, {7'h0, fen}, 8'hff);
		wr(`OFS_IRQ_EN, 8'h0e);
		rd(`OFS_IRQ_ID, 8'hc1);
		// one char, trigger four: only the timer can raise it
		wr(`OFS_IRQ_ID, 8'h41);
		wr(`OFS_IRQ_EN, 8'h0d);
		cnt <= 5'd1;
		tick <= 1'b1;
		repeat (600) @(posedge clk);
		rd(`OFS_IRQ_ID, 8'hc1);
		repeat (100) @(posedge clk);
		rd(`OFS_IRQ_ID, 8'hcc);
		fread <= 1'b1;
		@(posedge clk);
		fread <= 1'b0;
		rd(`OFS_IRQ_ID, 8'hc1);
		// a new character restarts the timer; without it the 640-tick timeout expires within the 800 ticks waited
		repeat (400) @(posedge clk);
		stored <= 1'b1;
		@(posedge clk);
		stored <= 1'b0;
		repeat (400) @(posedge clk);
		rd(`OFS_IRQ_ID, 8'hc1);
		tick <= 1'b0;
		cnt <= 5'd0;
		wr(`OFS_IRQ_EN, 8'h02);
		txe <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`OFS_IRQ_ID, 8'hc2);
		rd(`OFS_IRQ_ID, 8'hc1);
		txe <= 1'b0;
		@(posedge clk);
		txe <= 1'b1;
		repeat (4) @(posedge clk);
		thw <= 1'b1;
		@(posedge clk);
		thw <= 1'b0;
		repeat (2) @(posedge clk);
		rd(`OFS_IRQ_ID, 8'hc1);
		wr(`OFS_IRQ_ID, 8'h00);
		rd(`OFS_IRQ_ID, 8'h01);
		cmp("fifo off", 8'h00, {7'h0, fen}, 8'hff);
		cmp("fifo clears", 8'h02, 8'(clr_cnt), 8'hff);
		results();
	end

	initial
	begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		results();
	end
endmodule
`default_nettype wire
